// >>> verilog/aot_offset_trim_regs.vh
// What this block does
// - defaults load from fuse storage, not zero
// - core 1 uses core-1 trim field
// - core 2 on pair A uses A trim
// - core 2 on pair B uses B trim
// - core 3 on pair C uses C trim
// - core 3 on pair D uses D trim
// - core 4 uses core-4 trim field
// - every trim field is unsigned
`ifndef AOT_OFFSET_TRIM_REGS_VH
`define AOT_OFFSET_TRIM_REGS_VH

// register indices; byte address is index times four
`define AOT_IDX_CORE1 10'h332
`define AOT_IDX_CORE2_A 10'h334
`define AOT_IDX_CORE2_B 10'h336
`define AOT_IDX_CORE3_C 10'h338
`define AOT_IDX_CORE3_D 10'h33A
`define AOT_IDX_CORE4 10'h33C
`define AOT_IDX_STATUS 10'h340
`define AOT_IDX_CONTROL 10'h341

// slot numbers inside the trim bank
`define AOT_SLOT_CORE1 3'h0
`define AOT_SLOT_CORE2_A 3'h1
`define AOT_SLOT_CORE2_B 3'h2
`define AOT_SLOT_CORE3_C 3'h3
`define AOT_SLOT_CORE3_D 3'h4
`define AOT_SLOT_CORE4 3'h5
`define AOT_SLOT_NONE 3'h7
`define AOT_SLOT_COUNT 6

// field layout and reset values
`define AOT_TRIM_MSB 11
`define AOT_RSV_MSB 15
`define AOT_RSV_LSB 12
`define AOT_TRIM_RST 16'h0000
`define AOT_RSV_ZERO 4'h0
`define AOT_CTRL_RELOAD_BIT 0
`define AOT_STAT_READY_BIT 0
`define AOT_STAT_SEL2_BIT 1
`define AOT_STAT_SEL3_BIT 2

// bus answers
`define AOT_RESP_OKAY 2'h0
`define AOT_RESP_SLVERR 2'h2

`endif

// >>> verilog/aot_offset_trim.v
// The implementer's own choice: the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
`include "aot_offset_trim_regs.vh"

module aot_offset_trim (
   input wire clk, // 100 MHz clock
   input wire rstn, // async reset, active low
   input wire [11:0] s_axi_awaddr, // write address
   input wire s_axi_awvalid, // write address valid
   output reg s_axi_awready, // write address ready
   input wire [31:0] s_axi_wdata, // write data
   input wire [3:0] s_axi_wstrb, // write byte strobes
   input wire s_axi_wvalid, // write data valid
   output reg s_axi_wready, // write data ready
   output reg [1:0] s_axi_bresp, // write response
   output reg s_axi_bvalid, // write response valid
   input wire s_axi_bready, // write response ready
   input wire [11:0] s_axi_araddr, // read address
   input wire s_axi_arvalid, // read address valid
   output reg s_axi_arready, // read address ready
   output reg [31:0] s_axi_rdata, // read data
   output reg [1:0] s_axi_rresp, // read response
   output reg s_axi_rvalid, // read data valid
   input wire s_axi_rready, // read data ready
   output reg fuse_rd_en, // fuse read request pulse
   output reg [2:0] fuse_addr, // fuse word being read
   input wire [15:0] fuse_rdata, // fuse word
   input wire fuse_rdata_valid, // fuse word valid pulse
   input wire core2_input_sel, // core 2 pair: 0 = A, 1 = B
   input wire core3_input_sel, // core 3 pair: 0 = C, 1 = D
   output reg [11:0] core1_offset, // offset applied to core 1
   output reg [11:0] core2_offset, // offset applied to core 2
   output reg [11:0] core3_offset, // offset applied to core 3
   output reg [11:0] core4_offset, // offset applied to core 4
   output reg trim_ready // fuse defaults loaded
);

   localparam [1:0] ST_LOAD_REQ = 2'h0;
   localparam [1:0] ST_LOAD_WAIT = 2'h1;
   localparam [1:0] ST_RUN = 2'h2;

   // word address to trim slot, shared by write and read paths
   function [2:0] trim_slot;
      input [11:0] addr;
      begin
         case (addr[11:2])
            `AOT_IDX_CORE1: trim_slot = `AOT_SLOT_CORE1;
            `AOT_IDX_CORE2_A: trim_slot = `AOT_SLOT_CORE2_A;
            `AOT_IDX_CORE2_B: trim_slot = `AOT_SLOT_CORE2_B;
            `AOT_IDX_CORE3_C: trim_slot = `AOT_SLOT_CORE3_C;
            `AOT_IDX_CORE3_D: trim_slot = `AOT_SLOT_CORE3_D;
            `AOT_IDX_CORE4: trim_slot = `AOT_SLOT_CORE4;
            default: trim_slot = `AOT_SLOT_NONE;
         endcase
      end
   endfunction

   reg [1:0] state;
   reg [2:0] load_slot;
   reg aw_held;
   reg w_held;
   reg [11:0] aw_addr_q;
   reg [31:0] w_data_q;
   reg [3:0] w_strb_q;
   reg [31:0] rd_word;
   reg [1:0] rd_resp;
   reg [2:0] rd_slot;
   reg reload_req;

   wire [15:0] trim_word [0:`AOT_SLOT_COUNT-1];
   wire wr_commit;
   wire [2:0] wr_slot;
   wire fuse_capture;

   assign wr_commit = aw_held && w_held && !s_axi_bvalid;
   assign wr_slot = trim_slot(aw_addr_q);
   assign fuse_capture = (state == ST_LOAD_WAIT) && fuse_rdata_valid;

   genvar g;
   generate
      for (g = 0; g < `AOT_SLOT_COUNT; g = g + 1)
      begin : trim_bank
         reg [15:0] q;
         always @(posedge clk or negedge rstn)
         begin
            if (!rstn)
            begin
               q <= `AOT_TRIM_RST;
            end
            else if (fuse_capture && load_slot == g)
            begin
               q <= {`AOT_RSV_ZERO, fuse_rdata[`AOT_TRIM_MSB:0]};
            end
            else if (wr_commit && wr_slot == g)
            begin
               // reserved bits stored as written, never applied
               if (w_strb_q[0])
               begin
                  q[7:0] <= w_data_q[7:0];
               end
               if (w_strb_q[1])
               begin
                  q[15:8] <= w_data_q[15:8];
               end
            end
         end
         assign trim_word[g] = q;
      end
   endgenerate

   // fuse walk runs after reset and on software reload
   always @(posedge clk or negedge rstn)
   begin
      if (!rstn)
      begin
         state <= ST_LOAD_REQ;
         load_slot <= 3'h0;
         fuse_rd_en <= 1'b0;
         fuse_addr <= 3'h0;
         trim_ready <= 1'b0;
      end
      else
      begin
         fuse_rd_en <= 1'b0;
         case (state)
            ST_LOAD_REQ:
            begin
               fuse_rd_en <= 1'b1;
               fuse_addr <= load_slot;
               state <= ST_LOAD_WAIT;
            end
            ST_LOAD_WAIT:
            begin
               if (fuse_rdata_valid)
               begin
                  if (load_slot == `AOT_SLOT_CORE4)
                  begin
                     load_slot <= 3'h0;
                     trim_ready <= 1'b1;
                     state <= ST_RUN;
                  end
                  else
                  begin
                     load_slot <= load_slot + 3'h1;
                     state <= ST_LOAD_REQ;
                  end
               end
            end
            ST_RUN:
            begin
               if (reload_req)
               begin
                  trim_ready <= 1'b0;
                  state <= ST_LOAD_REQ;
               end
            end
            default:
            begin
               state <= ST_LOAD_REQ;
            end
         endcase
      end
   end

   // write channel; bus is held off while the fuse walk runs
   always @(posedge clk or negedge rstn)
   begin
      if (!rstn)
      begin
         s_axi_awready <= 1'b0;
         s_axi_wready <= 1'b0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= `AOT_RESP_OKAY;
         aw_held <= 1'b0;
         w_held <= 1'b0;
         aw_addr_q <= 12'h000;
         w_data_q <= 32'h00000000;
         w_strb_q <= 4'h0;
         reload_req <= 1'b0;
      end
      else
      begin
         reload_req <= 1'b0;
         if (s_axi_awvalid && s_axi_awready)
         begin
            aw_addr_q <= s_axi_awaddr;
            aw_held <= 1'b1;
            s_axi_awready <= 1'b0;
         end
         if (s_axi_wvalid && s_axi_wready)
         begin
            w_data_q <= s_axi_wdata;
            w_strb_q <= s_axi_wstrb;
            w_held <= 1'b1;
            s_axi_wready <= 1'b0;
         end
         if (wr_commit)
         begin
            aw_held <= 1'b0;
            w_held <= 1'b0;
            s_axi_bvalid <= 1'b1;
            if (wr_slot != `AOT_SLOT_NONE)
            begin
               s_axi_bresp <= `AOT_RESP_OKAY;
            end
            else if (aw_addr_q[11:2] == `AOT_IDX_CONTROL)
            begin
               s_axi_bresp <= `AOT_RESP_OKAY;
               reload_req <= w_strb_q[0] && w_data_q[`AOT_CTRL_RELOAD_BIT];
            end
            else if (aw_addr_q[11:2] == `AOT_IDX_STATUS)
            begin
               s_axi_bresp <= `AOT_RESP_OKAY;
            end
            else
            begin
               s_axi_bresp <= `AOT_RESP_SLVERR;
            end
         end
         if (s_axi_bvalid && s_axi_bready)
         begin
            s_axi_bvalid <= 1'b0;
            s_axi_awready <= (state == ST_RUN) && !reload_req;
            s_axi_wready <= (state == ST_RUN) && !reload_req;
         end
         else if (state == ST_LOAD_WAIT && fuse_rdata_valid &&
                  load_slot == `AOT_SLOT_CORE4 && !s_axi_bvalid && !aw_held && !w_held)
         begin
            // open the bus when the walk finishes
            s_axi_awready <= 1'b1;
            s_axi_wready <= 1'b1;
         end
      end
   end

   // read data mux
   always @*
   begin
      rd_word = 32'h00000000;
      rd_resp = `AOT_RESP_OKAY;
      rd_slot = trim_slot(s_axi_araddr);
      if (rd_slot != `AOT_SLOT_NONE)
      begin
         rd_word[15:0] = trim_word[rd_slot];
      end
      else if (s_axi_araddr[11:2] == `AOT_IDX_STATUS)
      begin
         rd_word[`AOT_STAT_READY_BIT] = trim_ready;
         rd_word[`AOT_STAT_SEL2_BIT] = core2_input_sel;
         rd_word[`AOT_STAT_SEL3_BIT] = core3_input_sel;
      end
      else if (s_axi_araddr[11:2] != `AOT_IDX_CONTROL)
      begin
         rd_resp = `AOT_RESP_SLVERR;
      end
   end

   always @(posedge clk or negedge rstn)
   begin
      if (!rstn)
      begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h00000000;
         s_axi_rresp <= `AOT_RESP_OKAY;
      end
      else
      begin
         if (s_axi_arvalid && s_axi_arready)
         begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= rd_word;
            s_axi_rresp <= rd_resp;
         end
         else if (s_axi_rvalid && s_axi_rready)
         begin
            s_axi_rvalid <= 1'b0;
            s_axi_arready <= (state == ST_RUN) && !reload_req;
         end
         else if (!s_axi_rvalid)
         begin
            // read port follows the walk; a reload shuts it
            s_axi_arready <= (state == ST_RUN) && !reload_req;
         end
      end
   end

   // applied offsets, registered; fields pass through unsigned
   always @(posedge clk or negedge rstn)
   begin
      if (!rstn)
      begin
         core1_offset <= 12'h000;
         core2_offset <= 12'h000;
         core3_offset <= 12'h000;
         core4_offset <= 12'h000;
      end
      else
      begin
         core1_offset <= trim_word[`AOT_SLOT_CORE1][`AOT_TRIM_MSB:0];
         core2_offset <= core2_input_sel ? trim_word[`AOT_SLOT_CORE2_B][`AOT_TRIM_MSB:0]
                                         : trim_word[`AOT_SLOT_CORE2_A][`AOT_TRIM_MSB:0];
         core3_offset <= core3_input_sel ? trim_word[`AOT_SLOT_CORE3_D][`AOT_TRIM_MSB:0]
                                         : trim_word[`AOT_SLOT_CORE3_C][`AOT_TRIM_MSB:0];
         core4_offset <= trim_word[`AOT_SLOT_CORE4][`AOT_TRIM_MSB:0];
      end
   end

endmodule

// >>> dv/aot_trim_props.sv
`timescale 1ns/1ps
module aot_trim_props (
   input wire clk, // clock
   input wire rstn, // reset, active low
   input wire s_axi_awvalid, // aw valid
   input wire s_axi_awready, // aw ready
   input wire s_axi_wvalid, // w valid
   input wire s_axi_wready, // w ready
   input wire [1:0] s_axi_bresp, // b code
   input wire s_axi_bvalid, // b valid
   input wire s_axi_bready, // b ready
   input wire s_axi_arvalid, // ar valid
   input wire s_axi_arready, // ar ready
   input wire [31:0] s_axi_rdata, // r data
   input wire s_axi_rvalid, // r valid
   input wire s_axi_rready, // r ready
   input wire fuse_rd_en, // fuse request
   input wire [2:0] fuse_addr, // fuse word
   input wire fuse_rdata_valid, // fuse answer
   input wire trim_ready // defaults in
);
   default clocking @(posedge clk); endclocking
   default disable iff (!rstn);
   sequence s_fuse_ans;
      // next request goes out one edge after the word is captured, so it is sampled two edges after the answer
      fuse_rdata_valid ##2 fuse_rd_en;
   endsequence
   sequence s_wr_taken;
      s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
   endsequence
   a_fuse_order: assert property (s_fuse_ans |-> fuse_addr == $past(fuse_addr) + 3'h1)
      else $error("fuse words out of order");
   a_ready_after_fuse: assert property ($rose(trim_ready) |-> $past(fuse_rdata_valid) && $past(fuse_addr) == 3'h5)
      else $error("ready rose before last fuse word");
   a_walk_closed: assert property (!trim_ready |-> !s_axi_awready && !s_axi_wready && !s_axi_arready)
      else $error("bus open during fuse walk");
   a_fuse_pulse: assert property (fuse_rd_en |=> !fuse_rd_en)
      else $error("fuse request longer than one cycle");
   a_write_answer: assert property (s_wr_taken |=> !s_axi_awready && !s_axi_wready ##1 s_axi_bvalid)
      else $error("write response late");
   a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready)
      else $error("read response late");
   a_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
      else $error("write response dropped");
   a_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
      else $error("read data dropped");
   a_upper_zero: assert property (s_axi_rvalid |-> s_axi_rdata[31:16] == 16'h0000)
      else $error("upper read bits not zero");
endmodule
bind aot_offset_trim aot_trim_props i_aot_trim_props (.*);

// >>> dv/tb_top.sv
`timescale 1ns/1ps
`include "aot_offset_trim_regs.vh"
module tb_top;
   reg clk = 1'b0;
   reg rstn = 1'b0;
   reg [11:0] s_axi_awaddr = 12'h000;
   reg s_axi_awvalid = 1'b0;
   reg [31:0] s_axi_wdata = 32'h0;
   reg [3:0] s_axi_wstrb = 4'h0;
   reg s_axi_wvalid = 1'b0;
   reg s_axi_bready = 1'b0;
   reg [11:0] s_axi_araddr = 12'h000;
   reg s_axi_arvalid = 1'b0;
   reg s_axi_rready = 1'b0;
   reg [15:0] fuse_rdata = 16'h0;
   reg fuse_rdata_valid = 1'b0;
   reg core2_input_sel = 1'b0;
   reg core3_input_sel = 1'b0;
   wire s_axi_awready;
   wire s_axi_wready;
   wire [1:0] s_axi_bresp;
   wire s_axi_bvalid;
   wire s_axi_arready;
   wire [31:0] s_axi_rdata;
   wire [1:0] s_axi_rresp;
   wire s_axi_rvalid;
   wire fuse_rd_en;
   wire [2:0] fuse_addr;
   wire [11:0] core1_offset;
   wire [11:0] core2_offset;
   wire [11:0] core3_offset;
   wire [11:0] core4_offset;
   wire trim_ready;
   reg [15:0] fuse_mem [0:5];
   reg [15:0] shadow [0:5];
   reg [33:0] q [$];
   reg [11:0] v;
   integer miscompares = 0;
   integer compares = 0;
   integer seed = 55186;
   integer cycles = 0;
   integer fuse_cnt = 0;
   integer i;
   localparam [11:0] STAT = {`AOT_IDX_STATUS, 2'b00};
   localparam [11:0] CTRL = {`AOT_IDX_CONTROL, 2'b00};
   aot_offset_trim i_aot_offset_trim (.*);
   initial
   begin
      forever #5 clk = ~clk;
   end
   function [11:0] ba(input integer n);
      ba = 12'((`AOT_IDX_CORE1 + 2 * n) * 4);
   endfunction
   task chk(input [33:0] got, input [33:0] exp);
      begin
         compares = compares + 1;
         if (got !== exp)
         begin
            miscompares = miscompares + 1;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
         end
      end
   endtask
   task summarize;
      begin
         $display("compares=%0d miscompares=%0d", compares, miscompares);
         if (miscompares == 0 && compares > 0)
            $display("[ PASS ]");
         else
            $display("[ FAIL ]");
         $finish;
      end
   endtask
   task automatic wr(input [11:0] a, input [31:0] d, input [3:0] s, input [1:0] r);
      begin
         q.push_back({r, 32'h0});
         s_axi_awaddr <= a;
         s_axi_wdata <= d;
         s_axi_wstrb <= s;
         s_axi_awvalid <= 1'b1;
         s_axi_wvalid <= 1'b1;
         s_axi_bready <= 1'b1;
         forever
         begin
            @(posedge clk);
            if (s_axi_awvalid && s_axi_awready)
               s_axi_awvalid <= 1'b0;
            if (s_axi_wvalid && s_axi_wready)
               s_axi_wvalid <= 1'b0;
            if (s_axi_bvalid)
               break;
         end
         s_axi_bready <= 1'b0;
         // idle edge so the next call never re-raises ready in this step
         @(posedge clk);
      end
   endtask
   task automatic rd(input [11:0] a, input [31:0] e, input [1:0] r);
      begin
         q.push_back({r, e});
         s_axi_araddr <= a;
         s_axi_arvalid <= 1'b1;
         s_axi_rready <= 1'b1;
         forever
         begin
            @(posedge clk);
            if (s_axi_arvalid && s_axi_arready)
               s_axi_arvalid <= 1'b0;
            if (s_axi_rvalid)
               break;
         end
         s_axi_rready <= 1'b0;
         @(posedge clk);
      end
   endtask
   task load_shadow;
      for (i = 0; i < 6; i = i + 1)
         shadow[i] = {`AOT_RSV_ZERO, fuse_mem[i][11:0]};
   endtask
   task chk_out;
      begin
         chk(core1_offset, shadow[0][11:0]);
         chk(core2_offset, shadow[core2_input_sel ? 2 : 1][11:0]);
         chk(core3_offset, shadow[core3_input_sel ? 4 : 3][11:0]);
         chk(core4_offset, shadow[5][11:0]);
      end
   endtask
   // fuse answers next cycle; idle data toggles so stale words never look valid
   always @(posedge clk)
   begin
      fuse_rdata_valid <= fuse_rd_en;
      fuse_rdata <= fuse_rd_en ? fuse_mem[fuse_addr] : ~fuse_rdata;
      if (fuse_rdata_valid)
         fuse_cnt = fuse_cnt + 1;
      if (s_axi_rvalid && s_axi_rready)
         chk({s_axi_rresp, s_axi_rdata}, q.pop_front());
      if (s_axi_bvalid && s_axi_bready)
         chk({s_axi_bresp, 32'h0}, q.pop_front());
      cycles = cycles + 1;
      if (cycles == 5000)
      begin
         miscompares = miscompares + 1;
         summarize;
      end
   end
   initial
   begin
      for (i = 0; i < 6; i = i + 1)
         fuse_mem[i] = $random(seed);
      repeat (20) @(posedge clk);
      rstn <= 1'b1;
      while (trim_ready !== 1'b1)
         @(posedge clk);
      // offsets follow the bank one edge after the last capture
      @(posedge clk);
      load_shadow;
      chk_out;
      for (i = 0; i < 6; i = i + 1)
      begin
         rd(ba(i), shadow[i], `AOT_RESP_OKAY);
         v = (i == 0) ? 12'hFFF : (i == 5) ? 12'h000 : $random(seed);
         wr(ba(i), {20'h0, v}, 4'h3, `AOT_RESP_OKAY);
         shadow[i] = {`AOT_RSV_ZERO, v};
         rd(ba(i), shadow[i], `AOT_RESP_OKAY);
      end
      for (i = 0; i < 4; i = i + 1)
      begin
         core2_input_sel <= i[0];
         core3_input_sel <= i[1];
         repeat (3) @(posedge clk);
         chk_out;
         rd(STAT, {29'h0, i[1:0], 1'b1}, `AOT_RESP_OKAY);
      end
      wr(ba(5), 32'hFFFF_FFA5, 4'h1, `AOT_RESP_OKAY);
      shadow[5][7:0] = 8'hA5;
      wr(12'hD08, 32'h0000_0ABC, 4'h3, `AOT_RESP_SLVERR);
      rd(12'hD08, 32'h0, `AOT_RESP_SLVERR);
      wr(STAT, 32'h0000_0000, 4'h3, `AOT_RESP_OKAY);
      rd(ba(5), shadow[5], `AOT_RESP_OKAY);
      chk_out;
      for (i = 0; i < 6; i = i + 1)
         fuse_mem[i] = $random(seed);
      fuse_cnt = 0;
      wr(CTRL, 32'h0000_0001, 4'h3, `AOT_RESP_OKAY);
      while (fuse_cnt < 6)
         @(posedge clk);
      repeat (3) @(posedge clk);
      load_shadow;
      chk_out;
      for (i = 0; i < 6; i = i + 1)
         rd(ba(i), shadow[i], `AOT_RESP_OKAY);
      summarize;
   end
endmodule
